//--- clr_pkg.sv
// clr_pkg: constants and carrier types for the line readout timing generator.
// assumes a 250 MHz mclk; all sensor phases are driven as logic levels to external drivers.
package clr_pkg;
    // clock rate
    localparam int CLK_MHZ = 250;
    // horizontal line layout, in pixels
    localparam logic [11:0] EMPTY_PIX = 12'h004;
    localparam logic [11:0] DARK_PIX = 12'h010;
    localparam logic [11:0] ACTIVE_SINGLE = 12'h648;     // 1608
    localparam logic [11:0] ACTIVE_DUAL = 12'h324;       // 804
    localparam logic [11:0] LINE_SINGLE = 12'h66C;       // 1644
    localparam logic [11:0] LINE_DUAL = 12'h338;         // 824
    localparam logic [11:0] DARK_REF_FIRST = 12'h005;    // first of the 14 centre dark columns
    localparam logic [11:0] DARK_REF_LAST = 12'h012;     // last of the 14 centre dark columns
    // vertical frame layout, in rows
    localparam logic [11:0] FRAME_ROWS = 12'h4BE;        // 2 + 1208 + 4 = 1214
    // pixel period: 20 MHz full range or 40 MHz capped range
    localparam int PIX_SLOW_MHZ = 20;
    localparam int PIX_FAST_MHZ = 40;
    localparam logic [7:0] PIX_SLOW_CYC = 8'(CLK_MHZ / PIX_SLOW_MHZ + 1);  // rounded up: 13
    localparam logic [7:0] PIX_FAST_CYC = 8'((CLK_MHZ + PIX_FAST_MHZ - 1) / PIX_FAST_MHZ);
    // vertical pulse width and horizontal restart delay, in ns
    localparam int V_PULSE_NS = 1000;
    localparam int HD_NS = 1000;
    localparam logic [11:0] V_PULSE_CYC = 12'((V_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] HD_CYC = 12'((HD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] ZERO12 = 12'h000;
    localparam logic [7:0] ZERO8 = 8'h00;

    // horizontal drive bundle
    typedef struct packed {
        logic left_storage_a;
        logic left_storage_b;
        logic left_barrier_a;
        logic left_barrier_b;
        logic right_storage_a;
        logic right_storage_b;
        logic right_barrier_a;
        logic right_barrier_b;
        logic reset_gate_left;
        logic reset_gate_right;
    } clr_hdrive_t;

    // vertical and auxiliary drives
    typedef struct packed {
        logic vertical_phase_one;
        logic vertical_phase_two;
        logic fast_line_dump_gate;
        logic substrate_shutter;
    } clr_vdrive_t;

    // pixel tags for downstream sampling
    typedef struct packed {
        logic sample;       // one-cycle strobe: sample both video outputs now
        logic empty;
        logic dark;
        logic dark_ref;     // usable zero-signal reference column
        logic image;
        logic [11:0] column;
        logic [11:0] row;
    } clr_pixtag_t;
endpackage : clr_pkg

//--- clr_hphase.sv
// clr_hphase: maps the two horizontal phases onto the eight split-register inputs
// and pulses the reset gates; assumes phase levels arrive from flip-flops on mclk.
`timescale 1ns/10ps
module clr_hphase
    import clr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // phase levels and mode
    input wire logic phase_a,
    input wire logic reset_pulse,
    input wire logic dual_mode,
    // drive to sensor
    output clr_hdrive_t hdrive
);
    clr_hdrive_t next_hdrive;

    // all eight inputs from one register stage so edges line up within a clock
    always_comb begin
        next_hdrive.left_storage_a = phase_a;
        next_hdrive.left_barrier_a = phase_a;
        next_hdrive.right_storage_a = phase_a;
        next_hdrive.left_storage_b = ~phase_a;
        next_hdrive.left_barrier_b = ~phase_a;
        next_hdrive.right_storage_b = ~phase_a;
        next_hdrive.right_barrier_a = dual_mode ? phase_a : ~phase_a;
        next_hdrive.right_barrier_b = dual_mode ? ~phase_a : phase_a;
        next_hdrive.reset_gate_left = reset_pulse;
        next_hdrive.reset_gate_right = reset_pulse & dual_mode;
    end

    // registered so barrier edges coincide with the other clocks (one flop level)
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hdrive <= '{left_storage_a: 1'b1, left_barrier_a: 1'b1, right_storage_a: 1'b1,
                        right_barrier_b: 1'b1, default: 1'b0};
        end else begin
            hdrive <= next_hdrive;
        end
    end

    // the barrier swap follows the mode that was in force one register stage earlier
    property p_right_barrier_swap;
        @(posedge mclk) disable iff (!resetn)
        hdrive.right_barrier_a == ($past(dual_mode) ? hdrive.right_storage_a
                                                    : hdrive.right_storage_b);
    endproperty
    a_right_barrier_swap: assert property (p_right_barrier_swap)
        else $error("right barrier drive does not follow mode");
endmodule : clr_hphase

//--- clr_readout.sv
// clr_readout: timing generator for the interline sensor line transfer and readout.
// assumes external clock drivers buffer every phase output and converters sample video
// on the sample strobe; all control inputs come from logic on mclk.
// Functional notes
// - while vertical shifts, hold horizontal phase A high and phase B low
// - resume horizontal clocking only after restart delay from vertical falling edge
// - zero reference uses only the centre 14 of 16 dark columns
// - no shutter, vertical or dump pulse during horizontal shifting
// - single mode drive: A to storages and left A, right B barrier; B opposite
// - single mode issues 1644 horizontal cycles per line
// - dual mode swaps right barriers: A drives all A inputs, B all B
// - dual mode issues 824 horizontal cycles per line
// - right barrier edges coincide with other horizontal clocks within 3 ns
// - pulse reset gate after each pixel is sampled
// - 80000 electron full range needs the 20 MHz pixel clock
// - signals capped at 40000 electrons may use 40 MHz pixel clock
// - dual mode: right line reversed and appended after left line
`timescale 1ns/10ps
module clr_readout
    import clr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // frame control
    input wire logic frame_start,
    input wire logic dual_mode,
    input wire logic full_range,
    input wire logic dump_row,
    input wire logic shutter_req,
    // status
    output logic busy,
    output logic frame_done,
    // sensor drives
    output clr_vdrive_t vdrive,
    output clr_hdrive_t hdrive,
    // pixel tags toward the sampling path
    output clr_pixtag_t pixtag
);
    typedef enum logic [2:0] {
        CLR_IDLE,
        CLR_VPULSE,
        CLR_HOLD,
        CLR_HSHIFT,
        CLR_LINE_END
    } clr_state_t;

    clr_state_t state;
    clr_state_t next_state;
    logic [11:0] timer;
    logic [11:0] col;
    logic [11:0] row;
    logic [7:0] pix_cnt;
    logic phase_a;
    logic reset_pulse;
    logic mode_dual;
    logic mode_full;
    logic dump_this;

    // count helpers used by several decoders
    function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo,
                                      input logic [11:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    wire [11:0] line_len = mode_dual ? LINE_DUAL : LINE_SINGLE;
    wire [7:0] pix_len = mode_full ? PIX_SLOW_CYC : PIX_FAST_CYC;
    wire [7:0] pix_half = {1'b0, pix_len[7:1]};
    wire pix_last = (pix_cnt == pix_len - 8'h01);
    wire line_last = (col == line_len - 12'h001);
    wire row_last = (row == FRAME_ROWS - 12'h001);
    wire timer_done = (timer == ZERO12);
    wire hshift = (state == CLR_HSHIFT);
    wire col_empty = (col < EMPTY_PIX);
    wire col_dark_l = in_range(col, EMPTY_PIX, EMPTY_PIX + DARK_PIX - 12'h001);
    wire col_image = in_range(col, EMPTY_PIX + DARK_PIX,
                              EMPTY_PIX + DARK_PIX + (mode_dual ? ACTIVE_DUAL : ACTIVE_SINGLE)
                              - 12'h001);
    wire col_dark_r = !mode_dual && (col >= LINE_SINGLE - DARK_PIX);
    wire col_ref = in_range(col, DARK_REF_FIRST, DARK_REF_LAST)
                   || (col_dark_r && in_range(col - (LINE_SINGLE - DARK_PIX),
                                              12'h001, DARK_PIX - 12'h002));

    // sequencer: one vertical transfer then one full horizontal line per row
    always_comb begin
        next_state = state;
        unique case (state)
            CLR_IDLE: if (frame_start) next_state = CLR_VPULSE;
            CLR_VPULSE: if (timer_done) next_state = CLR_HOLD;
            CLR_HOLD: if (timer_done) next_state = CLR_HSHIFT;
            CLR_HSHIFT: if (pix_last && line_last) next_state = CLR_LINE_END;
            CLR_LINE_END: next_state = row_last ? CLR_IDLE : CLR_VPULSE;
        endcase
    end

    // state and mode latch; mode is taken only at frame start so a line never changes mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= CLR_IDLE;
            mode_dual <= 1'b0;
            mode_full <= 1'b0;
        end else begin
            state <= next_state;
            if (state == CLR_IDLE && frame_start) begin
                mode_dual <= dual_mode;
                mode_full <= full_range;
            end
        end
    end

    // interval timer for the vertical pulse and the restart delay
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timer <= ZERO12;
        end else if (next_state == CLR_VPULSE && state != CLR_VPULSE) begin
            timer <= V_PULSE_CYC - 12'h001;
        end else if (state == CLR_VPULSE && timer_done) begin
            timer <= HD_CYC - 12'h001;
        end else if (!timer_done) begin
            timer <= timer - 12'h001;
        end
    end

    // pixel and column counters
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pix_cnt <= ZERO8;
            col <= ZERO12;
        end else if (!hshift) begin
            pix_cnt <= ZERO8;
            col <= ZERO12;
        end else if (pix_last) begin
            pix_cnt <= ZERO8;
            col <= line_last ? ZERO12 : col + 12'h001;
        end else begin
            pix_cnt <= pix_cnt + 8'h01;
        end
    end

    // row counter and per-row dump request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            row <= ZERO12;
            dump_this <= 1'b0;
        end else begin
            if (state == CLR_IDLE) begin
                row <= ZERO12;
            end else if (state == CLR_LINE_END) begin
                row <= row + 12'h001;
            end
            if (next_state == CLR_VPULSE && state != CLR_VPULSE) begin
                dump_this <= dump_row;
            end
        end
    end

    // horizontal phase: A high first half of pixel, held high outside shifting
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_a <= 1'b1;
            reset_pulse <= 1'b0;
        end else begin
            phase_a <= !hshift || (pix_cnt < pix_half);
            reset_pulse <= hshift && pix_last;
        end
    end

    // vertical and auxiliary drives; quiet while shifting horizontally
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vdrive <= '0;
        end else begin
            vdrive.vertical_phase_one <= (state == CLR_VPULSE);
            vdrive.vertical_phase_two <= (state == CLR_VPULSE);
            vdrive.fast_line_dump_gate <= (state == CLR_VPULSE) && dump_this;
            vdrive.substrate_shutter <= shutter_req && (state == CLR_IDLE);
        end
    end

    // pixel tags, strobed in the middle of each pixel's B half
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pixtag <= '0;
        end else begin
            pixtag.sample <= hshift && (pix_cnt == pix_len - 8'h02);
            pixtag.empty <= col_empty;
            pixtag.dark <= col_dark_l || col_dark_r;
            pixtag.dark_ref <= col_ref;
            pixtag.image <= col_image;
            pixtag.column <= col;
            pixtag.row <= row;
        end
    end

    // status
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frame_done <= 1'b0;
        end else begin
            frame_done <= (state == CLR_LINE_END) && row_last;
        end
    end
    assign busy = (state != CLR_IDLE);

    // split register drive and reset gates (right output used only in dual mode)
    clr_hphase u_hphase (
        .mclk(mclk),
        .resetn(resetn),
        .phase_a(phase_a),
        .reset_pulse(reset_pulse),
        .dual_mode(mode_dual),
        .hdrive(hdrive)
    );

    // helper counters for the checks: cycles since the vertical fall, strobes in this line;
    // the delay counter saturates so a long line cannot wrap it back under the limit
    logic [11:0] since_vfall;
    logic [11:0] strobe_cnt;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            since_vfall <= ZERO12;
            strobe_cnt <= ZERO12;
        end else begin
            if (vdrive.vertical_phase_one) begin
                since_vfall <= ZERO12;
            end else if (since_vfall != 12'hFFF) begin
                since_vfall <= since_vfall + 12'h001;
            end
            if (state == CLR_HOLD) begin
                strobe_cnt <= ZERO12;
            end else if (pixtag.sample) begin
                strobe_cnt <= strobe_cnt + 12'h001;
            end
        end
    end

    // checks
    sequence s_h_resume;
        $fell(hdrive.left_storage_a);
    endsequence
    sequence s_no_strobe_6;
        !pixtag.sample [*6];
    endsequence
    property p_h_held_in_vpulse;
        @(posedge mclk) disable iff (!resetn)
        vdrive.vertical_phase_one |-> hdrive.left_storage_a && !hdrive.left_storage_b;
    endproperty
    a_h_held_in_vpulse: assert property (p_h_held_in_vpulse)
        else $error("horizontal phase moved during vertical pulse");
    property p_restart_delay;
        @(posedge mclk) disable iff (!resetn)
        s_h_resume |-> (since_vfall >= HD_CYC);
    endproperty
    a_restart_delay: assert property (p_restart_delay)
        else $error("horizontal clocking resumed too early");
    property p_no_v_in_hshift;
        @(posedge mclk) disable iff (!resetn)
        hshift |=> !vdrive.vertical_phase_one && !vdrive.fast_line_dump_gate
                   && !vdrive.substrate_shutter;
    endproperty
    a_no_v_in_hshift: assert property (p_no_v_in_hshift)
        else $error("vertical or dump pulse during horizontal shift");
    property p_dump_only_in_vpulse;
        @(posedge mclk) disable iff (!resetn)
        vdrive.fast_line_dump_gate |-> vdrive.vertical_phase_two;
    endproperty
    a_dump_only_in_vpulse: assert property (p_dump_only_in_vpulse)
        else $error("dump gate outside row transfer");
    property p_line_len;
        @(posedge mclk) disable iff (!resetn)
        (state == CLR_LINE_END) |-> (strobe_cnt == (mode_dual ? LINE_DUAL : LINE_SINGLE));
    endproperty
    a_line_len: assert property (p_line_len)
        else $error("line length wrong for mode");
    property p_reset_after_sample;
        @(posedge mclk) disable iff (!resetn)
        pixtag.sample |=> reset_pulse || !hshift;
    endproperty
    a_reset_after_sample: assert property (p_reset_after_sample)
        else $error("reset gate not pulsed after sample");
    property p_ref_in_dark;
        @(posedge mclk) disable iff (!resetn)
        pixtag.dark_ref |-> pixtag.dark;
    endproperty
    a_ref_in_dark: assert property (p_ref_in_dark)
        else $error("reference column outside dark band");
    property p_vpulse_then_line;
        @(posedge mclk) disable iff (!resetn)
        (state == CLR_LINE_END && !row_last) |=> (state == CLR_VPULSE);
    endproperty
    a_vpulse_then_line: assert property (p_vpulse_then_line)
        else $error("next line did not start with a vertical transfer");
    // strobes never closer than the fast pixel period of 7 clocks
    property p_pixel_rate;
        @(posedge mclk) disable iff (!resetn)
        pixtag.sample |=> s_no_strobe_6;
    endproperty
    a_pixel_rate: assert property (p_pixel_rate)
        else $error("pixel strobes closer than the fast pixel period");
endmodule : clr_readout

//--- clr_sensor_model.sv
// clr_sensor_model: behavioural interline sensor driven by the readout block.
// assumes clean logic-level phases; video is a charge code, all ones at reset level.
`timescale 1ns/10ps
module clr_sensor_model
    import clr_pkg::*;
#(
    parameter int TOTAL_ROWS = 1214,
    parameter int CELLS = 1648,
    parameter int HALF = 824
)
(
    // drives from the timing generator
    input wire clr_vdrive_t vdrive,
    input wire clr_hdrive_t hdrive,
    // video outputs
    output logic [31:0] left_video_output,
    output logic [31:0] right_video_output
);
    logic [31:0] hreg [CELLS];
    int rows_moved = 0;
    logic dump_seen = 1'b0;
    logic v_prev = 1'b0;
    logic a_prev = 1'b0;

    initial begin
        foreach (hreg[i]) hreg[i] = 32'h0;
        left_video_output = 32'hFFFF_FFFF;
        right_video_output = 32'hFFFF_FFFF;
    end

    // row moves on the falling edge; a dump seen during the pulse loses it
    always @(vdrive) begin
        if (vdrive.vertical_phase_one === 1'b1 && vdrive.fast_line_dump_gate === 1'b1) begin
            dump_seen = 1'b1;
        end
        if (v_prev === 1'b1 && vdrive.vertical_phase_one === 1'b0) begin
            for (int c = 0; c < CELLS - 8; c++) begin
                hreg[c + 4] = (dump_seen || rows_moved >= TOTAL_ROWS) ? 32'h0 :
                    32'(rows_moved * 4096 + c + 1);
            end
            rows_moved++;
            dump_seen = 1'b0;
        end
        v_prev = vdrive.vertical_phase_one;
    end

    // one packet per phase a fall; reset gates clear the sense nodes afterwards
    always @(hdrive) begin
        if (a_prev === 1'b1 && hdrive.left_storage_a === 1'b0) begin
            left_video_output = hreg[0];
            // right half runs opposite only when its barrier a follows storage a;
            // read here rather than from a net so the new drive is always seen
            if (hdrive.right_barrier_a === hdrive.right_storage_a) begin
                right_video_output = hreg[CELLS - 1];
                for (int i = 0; i < HALF - 1; i++) begin
                    hreg[i] = hreg[i + 1];
                end
                for (int i = CELLS - 1; i > HALF; i--) begin
                    hreg[i] = hreg[i - 1];
                end
                hreg[HALF - 1] = 32'h0;
                hreg[HALF] = 32'h0;
            end else begin
                // right amplifier unused: never a stale value
                right_video_output = ~right_video_output;
                for (int i = 0; i < CELLS - 1; i++) begin
                    hreg[i] = hreg[i + 1];
                end
                hreg[CELLS - 1] = 32'h0;
            end
        end
        if (hdrive.reset_gate_left === 1'b1) left_video_output = 32'hFFFF_FFFF;
        if (hdrive.reset_gate_right === 1'b1) right_video_output = 32'hFFFF_FFFF;
        a_prev = hdrive.left_storage_a;
    end
endmodule : clr_sensor_model

//--- clr_readout_tb_top.sv
// clr_readout_tb_top: self-checking bench for the line readout timing generator.
// assumes the sensor model on the drives; a full frame is too long, so lines are sampled.
`timescale 1ns/10ps
module clr_readout_tb_top
    import clr_pkg::*;
;
    typedef struct packed {
        logic dual;
        logic [11:0] col;
        logic [11:0] row;
        logic [3:0] flags;
        logic [31:0] lv;
        logic [31:0] rv;
    } clr_note_t;

    logic mclk = 1'b0;
    logic resetn, frame_start, dual_mode, full_range, dump_row, shutter_req;
    logic busy, frame_done;
    clr_vdrive_t vdrive;
    clr_hdrive_t hdrive;
    clr_pixtag_t pixtag;
    logic [31:0] lvid, rvid;
    logic [7:0] exp_pix;
    clr_note_t notes[$];
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int last_cyc = 0;
    int xfer = 0;
    logic rg_seen = 1'b0;

    clr_readout dut (.mclk(mclk), .resetn(resetn), .frame_start(frame_start),
        .dual_mode(dual_mode), .full_range(full_range), .dump_row(dump_row),
        .shutter_req(shutter_req), .busy(busy), .frame_done(frame_done),
        .vdrive(vdrive), .hdrive(hdrive), .pixtag(pixtag));
    clr_sensor_model sensor (.vdrive(vdrive), .hdrive(hdrive),
        .left_video_output(lvid), .right_video_output(rvid));

    // 250 MHz
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // expected tags and charge codes of pixel k; right side reads columns reversed
    function automatic clr_note_t make_note(int k, int row, int base, logic dual, logic dmp);
        clr_note_t n;
        n.dual = dual;
        n.col = 12'(k);
        n.row = 12'(row);
        n.flags = {k < 4, (k >= 4 && k < 20) || (!dual && k >= 1628),
            (k >= 5 && k <= 18) || (!dual && k >= 1629 && k <= 1642),
            k >= 20 && k < (dual ? 824 : 1628)};
        n.lv = (k < 4 || dmp) ? 32'h0 : 32'(base * 4096 + k - 3);
        n.rv = (k < 4 || dmp) ? 32'h0 : 32'(base * 4096 + 1644 - k);
        return n;
    endfunction : make_note

    // bounded wait for the next vertical pulse
    task automatic wait_vert();
        int k = 0;
        while (vdrive.vertical_phase_one !== 1'b0 && k < 30000) begin
            @(negedge mclk);
            k++;
        end
        while (vdrive.vertical_phase_one !== 1'b1 && k < 30000) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 30000) begin
            chk(32'h1, 32'h0);
            conclude();
        end
    endtask : wait_vert

    // one frame start plus one ignored mid-frame frame_start pulse, nlines full lines plus the first pixel of one more, then reset
    task automatic run_test(input string name, input logic dual, input logic full, int nlines);
        logic plan [0:7];
        int k;
        for (int i = 0; i <= nlines; i++) begin
            plan[i] = (i == nlines || i == 1) ? 1'b1 : (i == 0 ? 1'b0 : 1'($urandom % 2));
            for (k = 0; k < (i == nlines ? 1 : (dual ? 824 : 1644)); k++) begin
                notes.push_back(make_note(k, i, xfer + i, dual, plan[i]));
            end
        end
        exp_pix = full ? PIX_SLOW_CYC : PIX_FAST_CYC;
        dump_row <= plan[0];
        dual_mode <= dual;
        full_range <= full;
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        // mode inputs flipped after the take must be ignored
        dual_mode <= ~dual;
        full_range <= ~full;
        @(negedge mclk);
        chk(32'(busy), 32'h1);
        for (int i = 1; i <= nlines; i++) begin
            wait_vert();
            @(posedge mclk);
            dump_row <= plan[i];
            shutter_req <= 1'($urandom % 2);
            if (i == 1) begin
                repeat (300 + $urandom % 100) @(posedge mclk);
                frame_start <= 1'b1;
                @(posedge mclk);
                frame_start <= 1'b0;
            end
        end
        k = 0;
        while (notes.size() != 0 && k < 40000) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 40000) begin
            chk(32'h1, 32'h0);
            conclude();
        end
        // reset in mid-line; the pending line was dumped so the register is empty
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        xfer += nlines + 1;
        $display("test %s done", name);
    endtask : run_test

    // pixel monitor: every sample strobe takes the oldest note
    always @(negedge mclk) begin
        clr_note_t n;
        if (hdrive.reset_gate_left === 1'b1) rg_seen = 1'b1;
        if (resetn === 1'b1 && pixtag.sample === 1'b1) begin
            if (notes.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                n = notes.pop_front();
                chk(32'({pixtag.empty, pixtag.dark, pixtag.dark_ref, pixtag.image}),
                    32'(n.flags));
                chk(32'({pixtag.column, pixtag.row}), 32'({n.col, n.row}));
                chk(lvid, n.lv);
                if (n.dual) chk(rvid, n.rv);
                else chk(32'(hdrive.reset_gate_right), 32'h0);
                chk(32'(hdrive.right_barrier_a), 32'(n.dual ? hdrive.left_storage_a :
                    hdrive.left_storage_b));
                chk(32'(vdrive), 32'h0);
                if (n.col != 12'h000) chk(32'(cyc - last_cyc), 32'(exp_pix));
                if (n.col != 12'h000) chk(32'(rg_seen), 32'h1);
                chk(32'(frame_done), 32'h0);
                rg_seen = 1'b0;
                last_cyc = cyc;
            end
        end
    end

    // vertical pulse width, then horizontal phases parked through the restart delay
    initial begin
        int n;
        logic bad;
        forever begin
            @(posedge vdrive.vertical_phase_one);
            n = 0;
            bad = 1'b0;
            do begin
                @(negedge mclk);
                if (vdrive.vertical_phase_one === 1'b1) n++;
                bad |= hdrive.left_storage_a !== 1'b1 || hdrive.left_storage_b !== 1'b0 ||
                    vdrive.vertical_phase_two !== vdrive.vertical_phase_one;
            end while (vdrive.vertical_phase_one === 1'b1 && n < 1000);
            chk(32'(n), 32'(V_PULSE_CYC));
            repeat (HD_CYC) begin
                @(negedge mclk);
                bad |= hdrive.left_storage_a !== 1'b1 || hdrive.left_storage_b !== 1'b0;
            end
            chk(32'(bad), 32'h0);
        end
    end

    initial begin
        resetn = 1'b0;
        frame_start = 1'b0;
        dual_mode = 1'b0;
        full_range = 1'b0;
        dump_row = 1'b0;
        shutter_req = 1'b0;
        void'($urandom(32'h86C7));
        @(posedge mclk);
        @(negedge mclk);
        chk(32'({busy, vdrive, hdrive.left_storage_a}), 32'h1);
        @(posedge mclk);
        resetn <= 1'b1;
        run_test("single fast", 1'b0, 1'b0, 3);
        run_test("dual full range", 1'b1, 1'b1, 2);
        conclude();
    end
endmodule : clr_readout_tb_top
